// ==== logic/crsq_carry.sv ====
// 8-bit add/subtract with carry and borrow out
`timescale 1ns/1ps
`default_nettype none
module crsq_carry (
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire logic       sub,
    output logic [7:0]      res,
    output logic            carry
);
    logic [8:0] wide;
    always_comb begin
        if (sub) begin
            wide = {1'b0, a} - {1'b0, b};
        end else begin
            wide = {1'b0, a} + {1'b0, b};
        end
        res   = wide[7:0];
        carry = wide[8];
    end
endmodule
`default_nettype wire

// ==== logic/crsq_prio.sv ====
// Fixed-priority pending interrupt selector, lowest index highest priority
`timescale 1ns/1ps
`default_nettype none
module crsq_prio #(
    parameter int N = 8
) (
    input  wire logic [N-1:0]         req,
    output logic                      any,
    output logic [$clog2(N)-1:0]      idx
);
    if (N < 2) begin : g_bad_n
        $error("crsq_prio: N must be at least 2");
    end
    always_comb begin
        any = |req;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = i[$clog2(N)-1:0];
            end
        end
    end
endmodule
`default_nettype wire

// ==== logic/crsq_seq.sv ====
// Reset, interrupt, low-power and debug-entry sequencer of the CPU
// Behaviour
// - Reset aborts current instruction immediately
// - Reset ends after source check and pin release
// - Six-cycle reset vector fetch, high byte first
// - Interrupts taken only at instruction boundary
// - Vector from highest pending at entry start
// - Push PC low, PC high, X, A, flags
// - Set mask after flags pushed
// - Vector high, low, idle, three queue fetches
// - Upper index byte never stacked
// - Software trap ignores the interrupt mask
// - Wait clears mask, stops clocks, wakes normally
// - Debug command in wait enters background
// - Stop may keep periodic wake clock running
// - Debug enable keeps oscillator on in stop
// - Debug command in stop enters background; the code does so only while debug enable is set
// - Debug instruction halts; go, trace, tagged-go resume
// - Breakpoint opcode forces background state
// - Flag bits V7 H4 I3 N2 Z1 C0
// - Carry from bit 7 or borrow
// - 16-bit values stored big-endian
`timescale 1ns/1ps
`default_nettype none
module crsq_seq
    import crsq_pkg::*;
#(
    parameter int NIRQ = NUM_IRQ
) (
    // Clock and reset
    input  wire logic             CLK,
    input  wire logic             RESET,
    // Reset sources
    input  wire logic             RESET_PIN_N,
    input  wire logic             SOURCE_CHECK_DONE,
    // Instruction boundary events from the core
    input  wire logic             INSN_BOUNDARY,
    input  wire logic             SOFTWARE_TRAP_INSTRUCTION,
    input  wire logic             DEBUG_ENTRY_INSTRUCTION,
    input  wire logic             WAIT_INSTRUCTION,
    input  wire logic             STOP_INSTRUCTION,
    input  wire logic             STOP_KEEP_CLOCKS,
    input  wire logic             PERIODIC_WAKE,
    // Interrupt requests and their vectors
    input  wire logic [NIRQ-1:0]  IRQ_REQ,
    input  wire logic [15:0]      TRAP_VEC_ADDR,
    input  wire logic [15:0]      IRQ_VEC_BASE,
    // Core register values to stack
    input  wire logic [15:0]      PROG_COUNTER,
    input  wire logic [7:0]       INDEX_LOW,
    input  wire logic [7:0]       ACCUM,
    input  wire logic [7:0]       CONDITION_FLAGS_IN,
    input  wire logic [15:0]      STACK_PTR_IN,
    // Flag update from arithmetic
    input  wire logic             ALU_EN,
    input  wire logic             ALU_SUB,
    input  wire logic [7:0]       ALU_A,
    input  wire logic [7:0]       ALU_B,
    // Debug controller
    input  wire logic             DEBUG_CMD_VALID,
    input  wire logic [1:0]       DEBUG_CMD,
    input  wire logic             DEBUG_ENABLE_SET,
    // Memory bus
    output logic [15:0]           BUS_ADDR,
    output logic [7:0]            BUS_WDATA,
    output logic                  BUS_WRITE,
    output logic                  BUS_READ,
    input  wire logic [7:0]       BUS_RDATA,
    // Status
    output logic [15:0]           NEW_PC,
    output logic [15:0]           STACK_PTR,
    output logic [7:0]            CONDITION_FLAGS,
    output logic                  CPU_CLK_EN,
    output logic                  OSC_KEEP_ON,
    output logic                  ACTIVE_BACKGROUND,
    output logic                  RUNNING,
    output logic                  DEBUG_ENABLE_BIT
);
    localparam int IW = $clog2(NIRQ);
    if (NIRQ < 2 || NIRQ > 64) begin : g_bad_nirq
        $error("crsq_seq: NIRQ out of range");
    end

    // ----------------------------------------------------------------
    // Priority and carry helpers
    // ----------------------------------------------------------------
    logic          irq_any;
    logic [IW-1:0] irq_idx;
    logic          alu_carry;

    crsq_prio #(.N(NIRQ)) u_prio (
        .req (IRQ_REQ),
        .any (irq_any),
        .idx (irq_idx)
    );
    crsq_carry u_carry (
        .a     (ALU_A),
        .b     (ALU_B),
        .sub   (ALU_SUB),
        .res   (),
        .carry (alu_carry)
    );

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    crsq_state_e state_q, state_d;
    logic [2:0]  cnt_q, cnt_d;
    logic [15:0] vec_q, vec_d;
    logic [15:0] pc_q, pc_d;
    logic [15:0] sp_q, sp_d;
    logic [7:0]  flags_q, flags_d;
    logic [7:0]  snap_q [STACK_BYTES];
    logic [7:0]  snap_d [STACK_BYTES];
    logic        dbg_en_q, dbg_en_d;
    logic [15:0] addr_q, addr_d;
    logic [7:0]  wdata_q, wdata_d;
    logic        wr_q, wr_d, rd_q, rd_d;
    logic        clken_q, clken_d;
    logic        irq_ok;

    // Trap is never masked; hardware requests obey the mask
    assign irq_ok = irq_any && !flags_q[FLAG_I];

    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        vec_d    = vec_q;
        pc_d     = pc_q;
        sp_d     = sp_q;
        flags_d  = flags_q;
        snap_d   = snap_q;
        dbg_en_d = dbg_en_q || DEBUG_ENABLE_SET;
        addr_d   = addr_q;
        wdata_d  = 8'h00;
        wr_d     = 1'b0;
        rd_d     = 1'b0;
        clken_d  = 1'b1;
        if (ALU_EN && state_q == ST_RUN) begin
            flags_d[FLAG_C] = alu_carry;
        end
        case (state_q)
            ST_RESET: begin
                cnt_d = '0;
                if (SOURCE_CHECK_DONE && RESET_PIN_N) begin
                    state_d = ST_RVEC;
                end
            end
            ST_RVEC: begin
                cnt_d = cnt_q + 3'd1;
                case (cnt_q)
                    3'd0: begin
                        addr_d = RESET_VEC_HI_ADDR;
                        rd_d   = 1'b1;
                    end
                    3'd1: begin
                        addr_d = RESET_VEC_LO_ADDR;
                        rd_d   = 1'b1;
                    end
                    default: begin
                        rd_d = (cnt_q > 3'd2);
                    end
                endcase
                // Registered memory: data stand the cycle after the address
                if (cnt_q == 3'd2) pc_d[15:8] = BUS_RDATA;
                if (cnt_q == 3'd3) begin
                    pc_d[7:0] = BUS_RDATA;
                    addr_d    = {pc_q[15:8], BUS_RDATA};
                end
                if (cnt_q > 3'd3) addr_d = addr_q + WORD_STEP;
                if (cnt_q == 3'd5) begin
                    state_d = dbg_en_q ? ST_BDM : ST_RUN;
                    cnt_d   = '0;
                end
            end
            ST_RUN: begin
                if (INSN_BOUNDARY) begin
                    snap_d[0] = PROG_COUNTER[7:0];
                    snap_d[1] = PROG_COUNTER[15:8];
                    snap_d[2] = INDEX_LOW;
                    snap_d[3] = ACCUM;
                    snap_d[4] = CONDITION_FLAGS_IN;
                    flags_d   = CONDITION_FLAGS_IN;
                    sp_d      = STACK_PTR_IN;
                    cnt_d     = '0;
                    if (DEBUG_ENTRY_INSTRUCTION) begin
                        state_d = ST_BDM;
                    end else if (SOFTWARE_TRAP_INSTRUCTION) begin
                        vec_d   = TRAP_VEC_ADDR;
                        state_d = ST_PUSH;
                    end else if (irq_ok) begin
                        vec_d   = IRQ_VEC_BASE - {{(15-IW){1'b0}}, irq_idx, 1'b0};
                        state_d = ST_PUSH;
                    end else if (WAIT_INSTRUCTION) begin
                        flags_d[FLAG_I] = 1'b0;
                        state_d = ST_WAIT;
                    end else if (STOP_INSTRUCTION) begin
                        state_d = ST_STOP;
                    end
                end
            end
            ST_PUSH: begin
                addr_d  = sp_q;
                wdata_d = snap_q[cnt_q];
                wr_d    = 1'b1;
                sp_d    = sp_q - WORD_STEP;
                cnt_d   = cnt_q + 3'd1;
                if (cnt_q == 3'(STACK_BYTES - 1)) state_d = ST_SETI;
            end
            ST_SETI: begin
                flags_d[FLAG_I] = 1'b1;
                state_d = ST_VECHI;
            end
            ST_VECHI: begin
                addr_d  = vec_q;
                rd_d    = 1'b1;
                state_d = ST_VECLO;
            end
            ST_VECLO: begin
                addr_d  = vec_q + WORD_STEP;
                rd_d    = 1'b1;
                state_d = ST_FREE;
            end
            ST_FREE: begin
                pc_d[15:8] = BUS_RDATA;
                state_d    = ST_FILL;
                cnt_d      = '0;
            end
            ST_FILL: begin
                if (cnt_q == 3'd0) begin
                    pc_d[7:0] = BUS_RDATA;
                    addr_d    = {pc_q[15:8], BUS_RDATA};
                end else begin
                    addr_d = addr_q + WORD_STEP;
                end
                rd_d  = 1'b1;
                cnt_d = cnt_q + 3'd1;
                if (cnt_q == 3'(QUEUE_FILL_BYTES - 1)) state_d = ST_RUN;
            end
            ST_WAIT: begin
                clken_d = 1'b0;
                if (DEBUG_CMD_VALID) begin
                    state_d = ST_BDM;
                end else if (irq_any) begin
                    // Wait already ended its instruction: enter at once
                    snap_d[4] = flags_q;
                    vec_d     = IRQ_VEC_BASE - {{(15-IW){1'b0}}, irq_idx, 1'b0};
                    cnt_d     = '0;
                    state_d   = ST_PUSH;
                end
            end
            ST_STOP: begin
                clken_d = 1'b0;
                if (DEBUG_CMD_VALID && dbg_en_q) begin
                    state_d = ST_BDM;
                end else if (irq_any || (STOP_KEEP_CLOCKS && PERIODIC_WAKE)) begin
                    state_d = ST_RUN;
                end
            end
            ST_BDM: begin
                if (DEBUG_CMD_VALID && DEBUG_CMD != CMD_OTHER) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RESET;
            end
        endcase
        if (wr_d || rd_d) clken_d = 1'b1;
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            state_q  <= ST_RESET;
            cnt_q    <= '0;
            vec_q    <= '0;
            pc_q     <= '0;
            sp_q     <= '0;
            flags_q  <= FLAGS_RESET;
            for (int i = 0; i < STACK_BYTES; i++) snap_q[i] <= 8'h00;
            dbg_en_q <= 1'b0;
            addr_q   <= '0;
            wdata_q  <= 8'h00;
            wr_q     <= 1'b0;
            rd_q     <= 1'b0;
            clken_q  <= 1'b1;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            vec_q    <= vec_d;
            pc_q     <= pc_d;
            sp_q     <= sp_d;
            flags_q  <= flags_d;
            snap_q   <= snap_d;
            dbg_en_q <= dbg_en_d;
            addr_q   <= addr_d;
            wdata_q  <= wdata_d;
            wr_q     <= wr_d;
            rd_q     <= rd_d;
            clken_q  <= clken_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all registered
    // ----------------------------------------------------------------
    logic osc_q, bdm_q, run_q;
    always_ff @(posedge CLK) begin
        if (RESET) begin
            osc_q <= 1'b0;
            bdm_q <= 1'b0;
            run_q <= 1'b0;
        end else begin
            osc_q <= (state_d != ST_STOP) || dbg_en_d || STOP_KEEP_CLOCKS;
            bdm_q <= (state_d == ST_BDM);
            run_q <= (state_d == ST_RUN);
        end
    end

    assign BUS_ADDR          = addr_q;
    assign BUS_WDATA         = wdata_q;
    assign BUS_WRITE         = wr_q;
    assign BUS_READ          = rd_q;
    assign NEW_PC            = pc_q;
    assign STACK_PTR         = sp_q;
    assign CONDITION_FLAGS   = flags_q;
    assign CPU_CLK_EN        = clken_q;
    assign OSC_KEEP_ON       = osc_q;
    assign ACTIVE_BACKGROUND = bdm_q;
    assign RUNNING           = run_q;
    assign DEBUG_ENABLE_BIT  = dbg_en_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_push_done;
        state_q == ST_PUSH && cnt_q == 3'd4;
    endsequence
    sequence s_mask_set;
        ##1 state_q == ST_SETI ##1 flags_q[FLAG_I];
    endsequence

    AST_RESET_ABORT: assert property (@(posedge CLK) RESET |=> state_q == ST_RESET)
        else $error("reset did not abort");
    AST_RESET_END: assert property (@(posedge CLK) disable iff (RESET)
        (state_q == ST_RESET && !RESET_PIN_N) |=> state_q != ST_RVEC)
        else $error("reset ended with pin low");
    AST_RESET_VEC: assert property (@(posedge CLK) disable iff (RESET)
        (state_q == ST_RVEC && cnt_q == 3'd0) |=> BUS_ADDR == RESET_VEC_HI_ADDR && BUS_READ
        ##1 BUS_ADDR == RESET_VEC_LO_ADDR)
        else $error("reset vector fetch wrong");
    AST_MASK_AFTER_PUSH: assert property (@(posedge CLK) disable iff (RESET)
        s_push_done |-> s_mask_set)
        else $error("mask not set after push");
    AST_SP_DEC: assert property (@(posedge CLK) disable iff (RESET)
        state_q == ST_PUSH |=> sp_q == $past(sp_q) - WORD_STEP)
        else $error("stack pointer not decremented");
    AST_WAIT_MASK: assert property (@(posedge CLK) disable iff (RESET)
        (state_q == ST_RUN && state_d == ST_WAIT) |=> !flags_q[FLAG_I] ##1 !CPU_CLK_EN)
        else $error("wait entry wrong");
    AST_WAIT_DEBUG: assert property (@(posedge CLK) disable iff (RESET)
        (state_q == ST_WAIT && DEBUG_CMD_VALID) |=> ##1 ACTIVE_BACKGROUND)
        else $error("debug command in wait ignored");
    AST_STOP_OSC: assert property (@(posedge CLK) disable iff (RESET)
        (state_q == ST_STOP && dbg_en_q) |-> OSC_KEEP_ON)
        else $error("oscillator stopped with debug enabled");
    AST_BDM_HOLD: assert property (@(posedge CLK) disable iff (RESET)
        (state_q == ST_BDM && !DEBUG_CMD_VALID) |=> state_q == ST_BDM)
        else $error("left background without command");
    AST_FILL_THREE: assert property (@(posedge CLK) disable iff (RESET)
        state_q == ST_FREE |=> !BUS_READ ##1 (BUS_READ [*2]) ##1 (BUS_READ && state_q == ST_RUN))
        else $error("queue fill not three reads");
endmodule
`default_nettype wire

// ==== pkg/crsq_pkg.sv ====
// Package: constants for the CPU special-operation sequencer
package crsq_pkg;
    // Vector addresses
    localparam logic [15:0] RESET_VEC_HI_ADDR = 16'hFFFE;
    localparam logic [15:0] RESET_VEC_LO_ADDR = 16'hFFFF;
    localparam logic [15:0] WORD_STEP         = 16'h0001;
    // Condition flag bit positions
    localparam int FLAG_V = 7;
    localparam int FLAG_H = 4;
    localparam int FLAG_I = 3;
    localparam int FLAG_N = 2;
    localparam int FLAG_Z = 1;
    localparam int FLAG_C = 0;
    localparam logic [7:0] FLAGS_RESET = 8'h08;
    // Sequence lengths
    localparam int RESET_SEQ_CYCLES = 6;
    localparam int QUEUE_FILL_BYTES = 3;
    localparam int STACK_BYTES      = 5;
    localparam int NUM_IRQ          = 8;
    // Host debug command codes
    localparam logic [1:0] CMD_OTHER  = 2'h0;
    localparam logic [1:0] CMD_GO     = 2'h1;
    localparam logic [1:0] CMD_TRACE  = 2'h2;
    localparam logic [1:0] CMD_TAGGED_GO = 2'h3;
    // Sequencer states, one-hot
    typedef enum logic [11:0] {
        ST_RESET  = 12'h001,
        ST_RVEC   = 12'h002,
        ST_RUN    = 12'h004,
        ST_PUSH   = 12'h008,
        ST_SETI   = 12'h010,
        ST_VECHI  = 12'h020,
        ST_VECLO  = 12'h040,
        ST_FREE   = 12'h080,
        ST_FILL   = 12'h100,
        ST_WAIT   = 12'h200,
        ST_STOP   = 12'h400,
        ST_BDM    = 12'h800
    } crsq_state_e;
endpackage

// ==== tb/crsq_mem_model.sv ====
// Memory model that answers the sequencer's bus reads one cycle later
`timescale 1ns/1ps
`default_nettype none
module crsq_mem_model (
    // Clock
    input  wire logic        clk,
    // Bus from the sequencer
    input  wire logic [15:0] bus_addr,
    input  wire logic        bus_read,
    output logic [7:0]       bus_rdata
);
    logic [7:0] data_q = 8'hA5;

    function automatic logic [7:0] mem_val(input logic [15:0] a);
        return a[15:8] ^ a[7:0] ^ 8'h5A;
    endfunction

    // Idle cycles show the inverse of the last byte, so a late sample is caught
    always @(posedge clk) begin
        if (bus_read) begin
            data_q <= mem_val(bus_addr);
        end else begin
            data_q <= ~data_q;
        end
    end
    assign bus_rdata = data_q;
endmodule
`default_nettype wire

// ==== tb/crsq_seq_tb_top.sv ====
// Self-checking testbench of the CPU special-operation sequencer
`timescale 1ns/1ps
`default_nettype none
module crsq_seq_tb_top
    import crsq_pkg::*;
();
    logic        clk = 1'b0;
    logic        rst, pin_n, src_done, bnd, trap, dbgi, waiti, stopi, keep, pwake;
    logic        alu_en, alu_sub, dcv, dset, bwr, brd, clk_en, osc_on, bg, running, dbg_bit;
    logic [7:0]  irq, xl, acc, fl_in, alu_a, alu_b, wdata, rdata, flags;
    logic [15:0] trap_vec, vec_base, pc, sp_in, bus_addr, new_pc, sp_out;
    logic [1:0]  dcmd;
    logic [40:0] acc_q [$];
    logic [15:0] cyc = 16'h0000;
    int          n_errors = 0;
    int          cmp_count = 0;

    always #5 clk = ~clk;
    // Log of bus accesses with the cycle they appeared in
    always @(negedge clk) begin
        cyc <= cyc + 16'h0001;
        if (brd | bwr) acc_q.push_back({cyc, bwr, bus_addr, wdata});
    end

    crsq_seq DUT (.CLK(clk), .RESET(rst), .RESET_PIN_N(pin_n), .SOURCE_CHECK_DONE(src_done),
        .INSN_BOUNDARY(bnd), .SOFTWARE_TRAP_INSTRUCTION(trap), .DEBUG_ENTRY_INSTRUCTION(dbgi),
        .WAIT_INSTRUCTION(waiti), .STOP_INSTRUCTION(stopi), .STOP_KEEP_CLOCKS(keep),
        .PERIODIC_WAKE(pwake), .IRQ_REQ(irq), .TRAP_VEC_ADDR(trap_vec), .IRQ_VEC_BASE(vec_base),
        .PROG_COUNTER(pc), .INDEX_LOW(xl), .ACCUM(acc), .CONDITION_FLAGS_IN(fl_in),
        .STACK_PTR_IN(sp_in), .ALU_EN(alu_en), .ALU_SUB(alu_sub), .ALU_A(alu_a), .ALU_B(alu_b),
        .DEBUG_CMD_VALID(dcv), .DEBUG_CMD(dcmd), .DEBUG_ENABLE_SET(dset), .BUS_ADDR(bus_addr),
        .BUS_WDATA(wdata), .BUS_WRITE(bwr), .BUS_READ(brd), .BUS_RDATA(rdata), .NEW_PC(new_pc),
        .STACK_PTR(sp_out), .CONDITION_FLAGS(flags), .CPU_CLK_EN(clk_en), .OSC_KEEP_ON(osc_on),
        .ACTIVE_BACKGROUND(bg), .RUNNING(running), .DEBUG_ENABLE_BIT(dbg_bit));

    crsq_mem_model PRT (.clk(clk), .bus_addr(bus_addr), .bus_read(brd), .bus_rdata(rdata));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Waits for n accesses, then confirms no extra one follows
    task automatic wait_acc(input int n);
        for (int i = 0; i < 60 && acc_q.size() < n; i++) @(posedge clk);
        tick(4);
        check("access count", acc_q.size(), n);
    endtask

    task automatic boundary(input logic [3:0] kind);
        bnd <= 1'b1;
        {dbgi, trap, waiti, stopi} <= kind;
        tick(1);
        bnd <= 1'b0;
        {dbgi, trap, waiti, stopi} <= 4'h0;
    endtask

    task automatic dbg_cmd(input logic [1:0] c);
        dcv <= 1'b1;
        dcmd <= c;
        tick(1);
        dcv <= 1'b0;
        tick(3);
    endtask

    task automatic exp_entry(input logic [15:0] vec, input logic [15:0] sp,
                             input logic [7:0] b [5]);
        logic [15:0] tgt;
        tgt = {PRT.mem_val(vec), PRT.mem_val(vec + WORD_STEP)};
        wait_acc(10);
        for (int i = 0; i < 5; i++) begin
            check("push", acc_q[i][24:0], {1'b1, sp - 16'(i), b[i]});
        end
        check("vec hi", acc_q[5][24:8], {1'b0, vec});
        check("vec lo", acc_q[6][24:8], {1'b0, vec + WORD_STEP});
        check("free cycle", acc_q[7][40:25] - acc_q[6][40:25], 16'h0002);
        for (int i = 0; i < 3; i++) begin
            check("queue fill", acc_q[7 + i][24:8], {1'b0, tgt + 16'(i)});
        end
        check("new pc", new_pc, tgt);
        check("mask set", flags[FLAG_I], 1'b1);
        check("sp after", sp_out, sp - 16'h0005);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic do_reset();
        logic [15:0] tgt;
        tgt = {PRT.mem_val(RESET_VEC_HI_ADDR), PRT.mem_val(RESET_VEC_LO_ADDR)};
        rst <= 1'b1;
        pin_n <= 1'b0;
        tick(20);
        rst <= 1'b0;
        tick(6);
        check("held by pin", {running, brd}, 2'b00);
        acc_q.delete();
        pin_n <= 1'b1;
        wait_acc(5);
        check("rvec hi", acc_q[0][24:8], {1'b0, RESET_VEC_HI_ADDR});
        check("rvec lo", acc_q[1][24:8], {1'b0, RESET_VEC_LO_ADDR});
        for (int i = 0; i < 3; i++) begin
            check("rfill", acc_q[2 + i][24:8], {1'b0, tgt + 16'(i)});
        end
        check("reset span", acc_q[4][40:25] - acc_q[0][40:25] <= 16'h0005, 1'b1);
        check("running", running, 1'b1);
        check("reset pc", new_pc, tgt);
        check("reset flags", flags, FLAGS_RESET);
    endtask

    task automatic alu_op(input logic sub, input logic [7:0] a, b, input logic c);
        alu_en <= 1'b1;
        alu_sub <= sub;
        alu_a <= a;
        alu_b <= b;
        tick(1);
        alu_en <= 1'b0;
        tick(2);
        check("carry", flags[FLAG_C], c);
    endtask

    task automatic t_wait_irq();
        fl_in <= 8'h00;
        boundary(4'b0010);
        tick(4);
        check("wait mask", flags[FLAG_I], 1'b0);
        check("wait clk", clk_en, 1'b0);
        acc_q.delete();
        irq <= 8'h28;
        for (int i = 0; i < 40 && acc_q.size() == 0; i++) @(posedge clk);
        irq <= 8'h29;
        exp_entry(vec_base - 16'h0006, sp_in, '{8'h5A, 8'hA5, 8'h11, 8'h22, 8'h00});
        check("wake clk", clk_en, 1'b1);
        irq <= 8'h00;
    endtask

    task automatic t_trap_masked();
        fl_in <= 8'h08;
        irq <= 8'h04;
        acc_q.delete();
        boundary(4'b0000);
        tick(15);
        check("masked irq", acc_q.size(), 0);
        pc <= 16'h1357;
        boundary(4'b0100);
        exp_entry(trap_vec, sp_in, '{8'h57, 8'h13, 8'h11, 8'h22, 8'h08});
        irq <= 8'h00;
    endtask

    task automatic t_wait_dbg();
        boundary(4'b0010);
        tick(4);
        check("wait clk", clk_en, 1'b0);
        dbg_cmd(CMD_OTHER);
        check("wait bg", {bg, clk_en}, 2'b11);
        dbg_cmd(CMD_GO);
        check("go", {bg, running}, 2'b01);
    endtask

    task automatic t_debug_entry_instruction();
        logic [1:0] cmds [3] = '{CMD_GO, CMD_TRACE, CMD_TAGGED_GO};
        for (int i = 0; i < 3; i++) begin
            boundary(4'b1000);
            tick(3);
            check("bg entry", {bg, running}, 2'b10);
            dbg_cmd(CMD_OTHER);
            check("bg held", bg, 1'b1);
            dbg_cmd(cmds[i]);
            check("bg left", bg, 1'b0);
        end
        boundary(4'b1000);
        tick(3);
        do_reset();
        check("bg reset", bg, 1'b0);
    endtask

    task automatic t_abort();
        boundary(4'b0100);
        tick(2);
        rst <= 1'b1;
        tick(1);
        #1;
        check("abort", {bwr, brd, running}, 3'b000);
        do_reset();
    endtask

    task automatic t_stop();
        keep <= 1'b1;
        boundary(4'b0001);
        tick(4);
        check("stop clk", {osc_on, clk_en}, 2'b10);
        dbg_cmd(CMD_OTHER);
        check("no dbg wake", bg, 1'b0);
        pwake <= 1'b1;
        tick(1);
        pwake <= 1'b0;
        tick(3);
        check("periodic wake", {running, clk_en}, 2'b11);
        dset <= 1'b1;
        tick(1);
        dset <= 1'b0;
        keep <= 1'b0;
        tick(2);
        check("dbg bit", dbg_bit, 1'b1);
        boundary(4'b0001);
        tick(4);
        check("osc on", {osc_on, clk_en}, 2'b10);
        dbg_cmd(CMD_OTHER);
        check("stop bg", {bg, clk_en}, 2'b11);
        dbg_cmd(CMD_GO);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        {rst, pin_n, src_done, bnd, trap, dbgi, waiti, stopi, keep, pwake} = 10'h280;
        {alu_en, alu_sub, dcv, dset, dcmd, irq} = 14'h0000;
        {xl, acc, fl_in, alu_a, alu_b} = {8'h11, 8'h22, 8'h00, 8'h00, 8'h00};
        {trap_vec, vec_base, pc, sp_in} = {16'hFFFC, 16'hFFF0, 16'hA55A, 16'h01FF};
        tick(1);
        do_reset();
        alu_op(1'b0, 8'hFF, 8'h01, 1'b1);
        alu_op(1'b0, 8'h7F, 8'h01, 1'b0);
        alu_op(1'b1, 8'h10, 8'h20, 1'b1);
        alu_op(1'b1, 8'h20, 8'h10, 1'b0);
        t_wait_irq();
        t_trap_masked();
        t_wait_dbg();
        t_debug_entry_instruction();
        t_abort();
        t_stop();
        conclude();
    end

    initial begin
        #100000;
        n_errors++;
        conclude();
    end
endmodule
`default_nettype wire
